/* logic/tepc_check.sv */
// Summary of operation
// - reverse read, not file mark: fault at last gap when count not odd
// - longitudinal character never parity checked in fault detector
// - nine-stage pattern register: syndrome, track byte, longitudinal check
// - set-correction order loads track byte from host data lines
// - xor-load control: each clock xors every stage with its input
// - shift control equals read phase one with correction clear
// - controller clear zeroes stages only when correction clear
// - uncorrected clock: store strobe fall, shift, phase one, no lrc
// - stage nine takes fault xor previous stage eight
// - stage nine set: stage one sets, stages four-seven complement
// - stage nine clear: plain one-stage shift
// - forward-read crc parity mismatch enters register; lrc never shifts it in, only clear, track-byte load or write-phase xor change it
// - record good when crc is 111010111 and pattern all zero
// - on mismatch shift crc until match, at most eight shifts, then uncorrectable; marker names failing channel
// - bus bits gated by inverse of load select
// - gated ones toggle stages at write-phase character present
// - record end with xor-load control: all clear flag if zero, else lrc error
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "tepc_params.svh"

module tepc_check (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [31:0]             s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  input  wire tepc_pkg::tepc_stage_type readRegBits,
  input  wire tepc_pkg::tepc_stage_type correctedBusBit,
  input  wire tepc_pkg::tepc_stage_type hostDataLine,
  input  wire tepc_pkg::tepc_stage_type crcValue,
  input  wire logic                    setCorrection,
  input  wire logic                    charPresentFlag,
  input  wire logic                    storeStrobe,
  input  wire logic                    shiftFlag,
  input  wire logic                    readPhaseOne,
  input  wire logic                    readPhaseTwo,
  input  wire logic                    writePhaseOne,
  input  wire logic                    crcCharTime,
  input  wire logic                    lrcCharTime,
  input  wire logic                    lastGapTime,
  input  wire logic                    reverseDir,
  input  wire logic                    noFileMarker,
  input  wire logic                    oddCount,
  input  wire logic                    controllerClear,
  input  wire logic                    compareStart,
  input  wire logic                    recordEnd,
  output logic                         parityFault,
  output logic                         patternShiftCtl,
  output logic                         xorLoadCtl,
  output logic                         patternAllClear,
  output logic                         lrcError,
  output logic                         irq
);
  import tepc_pkg::*;

  logic           correctionModeFlag;
  logic           loadSel;
  logic           awHeld;
  logic           wHeld;
  logic [31:0]    awAddr;
  logic [31:0]    wData;
  logic [3:0]     wStrb;
  logic [4:0]     intStatus;
  logic [4:0]     intMask;
  logic [4:0]     next_events;
  logic           prevStrobe;
  logic           prevCharPresent;
  logic           faultNow;
  logic           shiftNow;
  logic           xorNow;
  logic           clockUncorr;
  logic           clockWrite;
  logic           recordOk;
  logic           cmpFound;
  logic           cmpUncorr;
  logic [3:0]     cmpCount;
  tepc_cmp_type   cmpState;
  tepc_stage_type crcShadow;
  tepc_stage_type marker;
  tepc_stage_type failChannel;
  tepc_stage_type pattern;
  tepc_stage_type gatedBusBit;

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
    hit = ((addr & `TEPC_ADDR_MASK) == off);
  endfunction : hit

  function automatic logic mapped(input logic [31:0] addr);
    mapped = hit(addr, `TEPC_OFF_CTRL) || hit(addr, `TEPC_OFF_STATUS) ||
             hit(addr, `TEPC_OFF_CHANNEL) || hit(addr, `TEPC_OFF_INTSTAT) ||
             hit(addr, `TEPC_OFF_INTMASK);
  endfunction : mapped

  // fault detector and controls
  always_comb begin
    faultNow = 1'b0;
    if (readPhaseTwo && charPresentFlag && !(^readRegBits) && !crcCharTime && !lrcCharTime)
      faultNow = 1'b1;
    if (readPhaseTwo && charPresentFlag && crcCharTime && !reverseDir && !lrcCharTime &&
        (oddCount == (^readRegBits)))
      faultNow = 1'b1;
    if (lastGapTime && reverseDir && readPhaseTwo && noFileMarker && !oddCount)
      faultNow = 1'b1;
  end

  assign shiftNow    = readPhaseOne && !correctionModeFlag;
  assign xorNow      = writePhaseOne && !readPhaseOne;
  assign clockUncorr = prevStrobe && !storeStrobe && shiftFlag && shiftNow && !lrcCharTime;
  assign clockWrite  = xorNow && charPresentFlag && !prevCharPresent;
  assign gatedBusBit = correctedBusBit & {`TEPC_STAGES{!loadSel}};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prevStrobe      <= 1'b0;
      prevCharPresent <= 1'b0;
    end else begin
      prevStrobe      <= storeStrobe;
      prevCharPresent <= charPresentFlag;
    end
  end

  tepc_pattern_reg u_pattern (
    .clk      (clk),
    .nrst     (nrst),
    .clearEn  (controllerClear && !correctionModeFlag),
    .loadEn   (setCorrection),
    .loadData (hostDataLine),
    .xorEn    (clockWrite),
    .xorData  (gatedBusBit),
    .shiftEn  (clockUncorr),
    .faultIn  (faultNow),
    .pattern  (pattern)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      parityFault     <= 1'b0;
      patternShiftCtl <= 1'b0;
      xorLoadCtl      <= 1'b0;
    end else begin
      parityFault     <= faultNow;
      patternShiftCtl <= shiftNow;
      xorLoadCtl      <= xorNow;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      patternAllClear <= 1'b0;
      lrcError        <= 1'b0;
    end else if (controllerClear) begin
      patternAllClear <= 1'b0;
      lrcError        <= 1'b0;
    end else if (recordEnd && xorNow) begin
      patternAllClear <= (pattern == `TEPC_PAT_ZERO);
      lrcError        <= (pattern != `TEPC_PAT_ZERO);
    end
  end

  // crc comparison sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmpState    <= CMP_IDLE;
      crcShadow   <= `TEPC_PAT_ZERO;
      marker      <= `TEPC_PAT_ZERO;
      failChannel <= `TEPC_PAT_ZERO;
      cmpCount    <= `TEPC_CNT_ZERO;
      recordOk    <= 1'b0;
      cmpFound    <= 1'b0;
      cmpUncorr   <= 1'b0;
    end else begin
      recordOk  <= 1'b0;
      cmpFound  <= 1'b0;
      cmpUncorr <= 1'b0;
      case (cmpState)
        CMP_IDLE: begin
          if (compareStart) begin
            crcShadow <= crcValue;
            marker    <= `TEPC_MARK_FIRST;
            cmpCount  <= `TEPC_CNT_ZERO;
            cmpState  <= CMP_CHECK;
          end
        end
        CMP_CHECK: begin
          if (crcShadow == `TEPC_CRC_GOOD && pattern == `TEPC_PAT_ZERO) begin
            recordOk    <= 1'b1;
            failChannel <= `TEPC_PAT_ZERO;
            cmpState    <= CMP_IDLE;
          end else begin
            cmpState <= CMP_SEARCH;
          end
        end
        CMP_SEARCH: begin
          if (crcShadow == pattern) begin
            cmpFound    <= 1'b1;
            failChannel <= marker;
            cmpState    <= CMP_IDLE;
          end else if (cmpCount == `TEPC_CNT_MAX) begin
            cmpUncorr   <= 1'b1;
            failChannel <= `TEPC_PAT_ZERO;
            cmpState    <= CMP_IDLE;
          end else begin
            crcShadow <= {crcShadow[7:0], crcShadow[8]};
            marker    <= {marker[7:0], 1'b0};
            cmpCount  <= cmpCount + 4'h1;
          end
        end
        default: cmpState <= CMP_IDLE;
      endcase
    end
  end

  // write channel
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TEPC_RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= `TEPC_WORD_ZERO;
      wData         <= `TEPC_WORD_ZERO;
      wStrb         <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr) ? `TEPC_RESP_OKAY : `TEPC_RESP_SLVERR;
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  wire doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      correctionModeFlag <= 1'b0;
      loadSel            <= 1'b0;
      intMask            <= `TEPC_INT_ZERO;
    end else if (doWrite && wStrb[0]) begin
      if (hit(awAddr, `TEPC_OFF_CTRL)) begin
        correctionModeFlag <= wData[`TEPC_CTRL_CORR];
        loadSel            <= wData[`TEPC_CTRL_LDSEL];
      end else if (hit(awAddr, `TEPC_OFF_INTMASK)) begin
        intMask <= wData[4:0];
      end
    end
  end

  // sticky events, set wins over clear
  assign next_events = {recordOk, cmpUncorr, cmpFound,
                        recordEnd && xorNow && (pattern != `TEPC_PAT_ZERO), faultNow};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intStatus <= `TEPC_INT_ZERO;
    end else if (doWrite && wStrb[0] && hit(awAddr, `TEPC_OFF_INTSTAT)) begin
      intStatus <= (intStatus & ~wData[4:0]) | next_events;
    end else begin
      intStatus <= intStatus | next_events;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end

  // read channel
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `TEPC_WORD_ZERO;
      s_axi_rresp   <= `TEPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `TEPC_RESP_OKAY;
      s_axi_rdata   <= `TEPC_WORD_ZERO;
      if (hit(s_axi_araddr, `TEPC_OFF_CTRL)) begin
        s_axi_rdata[`TEPC_CTRL_CORR]  <= correctionModeFlag;
        s_axi_rdata[`TEPC_CTRL_LDSEL] <= loadSel;
      end else if (hit(s_axi_araddr, `TEPC_OFF_STATUS)) begin
        s_axi_rdata[8:0]              <= pattern;
        s_axi_rdata[`TEPC_ST_CLEAR]   <= patternAllClear;
        s_axi_rdata[`TEPC_ST_BUSY]    <= (cmpState != CMP_IDLE);
        s_axi_rdata[`TEPC_ST_OK]      <= (pattern == `TEPC_PAT_ZERO);
      end else if (hit(s_axi_araddr, `TEPC_OFF_CHANNEL)) begin
        s_axi_rdata[8:0] <= failChannel;
      end else if (hit(s_axi_araddr, `TEPC_OFF_INTSTAT)) begin
        s_axi_rdata[4:0] <= intStatus;
      end else if (hit(s_axi_araddr, `TEPC_OFF_INTMASK)) begin
        s_axi_rdata[4:0] <= intMask;
      end else begin
        s_axi_rresp <= `TEPC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  backward_gap_a: assert property (
    lastGapTime && reverseDir && readPhaseTwo && noFileMarker && !oddCount |=> parityFault)
    else $error("backward last-gap fault missing");

  lrc_no_fault_a: assert property (
    lrcCharTime && !(lastGapTime && reverseDir) |=> !parityFault)
    else $error("lrc character raised a fault");

  shift_ctl_a: assert property (
    ##1 patternShiftCtl == $past(readPhaseOne && !correctionModeFlag))
    else $error("shift control wrong");

  clear_keep_a: assert property (
    controllerClear && correctionModeFlag && !setCorrection && !clockWrite && !clockUncorr
    |=> $stable(pattern))
    else $error("clear hit loaded track byte");

  lrc_no_change_a: assert property (
    lrcCharTime && !controllerClear && !setCorrection && !clockWrite |=> $stable(pattern))
    else $error("lrc character changed pattern");

  track_load_a: assert property (
    setCorrection && !(controllerClear && !correctionModeFlag) |=> pattern == $past(hostDataLine))
    else $error("track byte not loaded");

  good_record_a: assert property (
    cmpState == CMP_CHECK && crcShadow == `TEPC_CRC_GOOD && pattern == `TEPC_PAT_ZERO
    |=> recordOk && cmpState == CMP_IDLE)
    else $error("good record not flagged");

  search_bound_a: assert property (
    cmpState == CMP_CHECK && !(crcShadow == `TEPC_CRC_GOOD && pattern == `TEPC_PAT_ZERO)
    |=> ##[1:10] cmpState == CMP_IDLE)
    else $error("channel search did not end");

  record_end_a: assert property (
    recordEnd && xorNow && !controllerClear
    |=> patternAllClear == ($past(pattern) == `TEPC_PAT_ZERO) && lrcError != patternAllClear)
    else $error("record end flags wrong");
endmodule : tepc_check

/* pkg/tepc_params.svh */
`ifndef TEPC_PARAMS_SVH
`define TEPC_PARAMS_SVH

// register byte offsets
`define TEPC_OFF_CTRL      32'h0000_0000
`define TEPC_OFF_STATUS    32'h0000_0004
`define TEPC_OFF_CHANNEL   32'h0000_0008
`define TEPC_OFF_INTSTAT   32'h0000_000c
`define TEPC_OFF_INTMASK   32'h0000_0010
`define TEPC_ADDR_MASK     32'h0000_00fc

// control fields
`define TEPC_CTRL_CORR     0
`define TEPC_CTRL_LDSEL    1

// status fields
`define TEPC_ST_CLEAR      9
`define TEPC_ST_BUSY       10
`define TEPC_ST_OK         11

// interrupt fields
`define TEPC_INT_PARITY    0
`define TEPC_INT_LRC       1
`define TEPC_INT_FOUND     2
`define TEPC_INT_UNCORR    3
`define TEPC_INT_OK        4
`define TEPC_INT_W         5

// values
`define TEPC_STAGES        9
`define TEPC_CRC_GOOD      9'h01d7
`define TEPC_PAT_ZERO      9'h0000
`define TEPC_MARK_FIRST    9'h0001
`define TEPC_CNT_MAX       4'h8
`define TEPC_CNT_ZERO      4'h0
`define TEPC_RESP_OKAY     2'h0
`define TEPC_RESP_SLVERR   2'h2
`define TEPC_WORD_ZERO     32'h0000_0000
`define TEPC_INT_ZERO      5'h00

`endif

/* pkg/tepc_pkg.sv */
package tepc_pkg;
  typedef logic [8:0] tepc_stage_type;
  typedef enum logic [1:0] {CMP_IDLE, CMP_CHECK, CMP_SEARCH} tepc_cmp_type;
endpackage : tepc_pkg

/* logic/tepc_pattern_reg.sv */
`timescale 1ns/10ps
`include "tepc_params.svh"

module tepc_pattern_reg (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    clearEn,
  input  wire logic                    loadEn,
  input  wire tepc_pkg::tepc_stage_type loadData,
  input  wire logic                    xorEn,
  input  wire tepc_pkg::tepc_stage_type xorData,
  input  wire logic                    shiftEn,
  input  wire logic                    faultIn,
  output tepc_pkg::tepc_stage_type      pattern
);
  import tepc_pkg::*;

  tepc_stage_type next_shift;

  always_comb begin
    next_shift    = pattern;
    next_shift[0] = pattern[8];
    next_shift[1] = pattern[0];
    next_shift[2] = pattern[1];
    next_shift[3] = pattern[2] ^ pattern[8];
    next_shift[4] = pattern[3] ^ pattern[8];
    next_shift[5] = pattern[4] ^ pattern[8];
    next_shift[6] = pattern[5] ^ pattern[8];
    next_shift[7] = pattern[6];
    next_shift[8] = faultIn ^ pattern[7];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pattern <= `TEPC_PAT_ZERO;
    end else if (clearEn) begin
      pattern <= `TEPC_PAT_ZERO;
    end else if (loadEn) begin
      pattern <= loadData;
    end else if (xorEn) begin
      pattern <= pattern ^ xorData;
    end else if (shiftEn) begin
      pattern <= next_shift;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  shift_feedback_a: assert property (
    shiftEn && !clearEn && !loadEn && !xorEn && pattern[8]
    |=> pattern[0] && (pattern[6:3] == ~$past(pattern[5:2])))
    else $error("stage nine feedback wrong");

  plain_shift_a: assert property (
    shiftEn && !clearEn && !loadEn && !xorEn && !pattern[8]
    |=> pattern[7:0] == {$past(pattern[6:0]), 1'b0})
    else $error("plain shift wrong");

  hold_value_a: assert property (
    !clearEn && !loadEn && !xorEn && !shiftEn |=> $stable(pattern))
    else $error("pattern changed while idle");

  xor_load_a: assert property (
    xorEn && !clearEn && !loadEn |=> pattern == ($past(pattern) ^ $past(xorData)))
    else $error("xor load wrong");
endmodule : tepc_pattern_reg

/* verification/tepc_tape_model.sv */
`timescale 1ns/10ps
module tepc_tape_model (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     sendReq,
  input  wire tepc_pkg::tepc_stage_type sendByte,
  output tepc_pkg::tepc_stage_type      readRegBits,
  output logic                          charPresentFlag,
  output logic                          storeStrobe,
  output logic                          sendDone
);
  import tepc_pkg::*;
  logic [2:0] step;
  // byte stands with strobe, strobe falls, then lines released inverted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step            <= 3'h0;
      readRegBits     <= 9'h000;
      charPresentFlag <= 1'b0;
      storeStrobe     <= 1'b0;
      sendDone        <= 1'b0;
    end else begin
      sendDone <= 1'b0;
      if (step == 3'h0 && sendReq) begin
        readRegBits     <= sendByte;
        charPresentFlag <= 1'b1;
        storeStrobe     <= 1'b1;
      end
      if (step == 3'h3)
        storeStrobe <= 1'b0;
      if (step == 3'h4) begin
        readRegBits     <= ~readRegBits;
        charPresentFlag <= 1'b0;
        sendDone        <= 1'b1;
      end
      if (step != 3'h0 || sendReq)
        step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
    end
  end
endmodule : tepc_tape_model

/* verification/test_tepc_check.sv */
`timescale 1ns/10ps
`include "tepc_params.svh"
module test_tepc_check;
  import tepc_pkg::*;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clk, nrst;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pf;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  tepc_stage_type readRegBits, correctedBusBit, hostDataLine, crcValue, sendByte, ex, cb;
  logic setCorrection, charPresentFlag, storeStrobe, shiftFlag, readPhaseOne, readPhaseTwo;
  logic writePhaseOne, crcCharTime, lrcCharTime, lastGapTime, reverseDir, noFileMarker;
  logic oddCount, controllerClear, compareStart, recordEnd, parityFault, patternShiftCtl;
  logic xorLoadCtl, patternAllClear, lrcError, irq, sendReq, sendDone;
  int n_errors = 0;
  int total_checks = 0;
  int k;
  tepc_check dut (.clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .readRegBits, .correctedBusBit, .hostDataLine, .crcValue, .setCorrection,
    .charPresentFlag, .storeStrobe, .shiftFlag, .readPhaseOne, .readPhaseTwo, .writePhaseOne,
    .crcCharTime, .lrcCharTime, .lastGapTime, .reverseDir, .noFileMarker, .oddCount,
    .controllerClear, .compareStart, .recordEnd, .parityFault, .patternShiftCtl, .xorLoadCtl,
    .patternAllClear, .lrcError, .irq);
  tepc_tape_model tape (.clk, .nrst, .sendReq, .sendByte, .readRegBits, .charPresentFlag,
    .storeStrobe, .sendDone);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  function tepc_stage_type shift_exp(tepc_stage_type p, logic f);
    shift_exp = {f ^ p[7], p[6], p[5:2] ^ {4{p[8]}}, p[1], p[0], p[8]};
  endfunction : shift_exp
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awready) aw = 1'b1;
      if (s_axi_wready) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    while (!s_axi_arready) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task send(input logic f);
    logic [7:0] d;
    d = 8'($urandom);
    @(posedge clk);
    sendReq <= 1'b1;
    sendByte <= {f ? ^d : ~^d, d};
    @(posedge clk);
    sendReq <= 1'b0;
    while (!sendDone) @(posedge clk);
    pf = parityFault;
  endtask : send
  task clr;
    @(posedge clk);
    controllerClear <= 1'b1;
    @(posedge clk);
    controllerClear <= 1'b0;
    rd(`TEPC_OFF_STATUS);
  endtask : clr
  task cmp(input tepc_stage_type crc, input tepc_stage_type p);
    wr(`TEPC_OFF_INTSTAT, 32'h0000_001f);
    hostDataLine <= p;
    crcValue <= crc;
    setCorrection <= 1'b1;
    @(posedge clk);
    setCorrection <= 1'b0;
    compareStart <= 1'b1;
    @(posedge clk);
    compareStart <= 1'b0;
    rdat = 32'h0000_0400;
    while (rdat[10]) rd(`TEPC_OFF_STATUS);
    rd(`TEPC_OFF_INTSTAT);
  endtask : cmp
  initial begin
    #(25ns * 20000);
    n_errors++;
    $display("mismatch at %0t: timeout", $time);
    finish_test();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sendReq} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, correctedBusBit, hostDataLine, crcValue} = '0;
    {setCorrection, shiftFlag, readPhaseOne, readPhaseTwo, writePhaseOne, crcCharTime} = '0;
    {lrcCharTime, lastGapTime, reverseDir, noFileMarker, oddCount, controllerClear} = '0;
    {compareStart, recordEnd, sendByte, nrst} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(28));
    tick(10);
    nrst <= 1'b1;
    rd(`TEPC_OFF_STATUS);
    check(rdat, 32'h0000_0800, "status reset");
    rd(32'h0000_0040);
    check(rdat, 32'h0000_0000, "unmapped read data");
    check(32'(rsp), 32'h2, "unmapped read resp");
    wr(32'h0000_0040, 32'hffff_ffff);
    check(32'(rsp), 32'h2, "unmapped write");
    k = $urandom_range(31, 0);
    wr(`TEPC_OFF_INTMASK, 32'(k));
    rd(`TEPC_OFF_INTMASK);
    check(rdat, 32'(k), "mask rw");
    wr(`TEPC_OFF_INTMASK, 32'h0000_0000);
    $display("test registers done");
    readPhaseOne <= 1'b1;
    readPhaseTwo <= 1'b1;
    shiftFlag <= 1'b1;
    wr(`TEPC_OFF_CTRL, 32'h0000_0000);
    check(32'(patternShiftCtl), 32'h1, "shift ctl on"); // shift control
    ex = 9'h000;
    for (int i = 0; i < 29; i++) begin
      k = (i < 17) ? ((17'h0a743 >> (16 - i)) & 1) : $urandom_range(1, 0);
      send(k[0]);
      check(32'(pf), 32'(k), "fault flag"); // fault input
      ex = shift_exp(ex, k[0]);
      if (i == 16) check(32'(ex), 32'h0000_0059, "shift table"); // table
    end
    rd(`TEPC_OFF_STATUS);
    check(32'(rdat[8:0]), 32'(ex), "syndrome"); // shift pattern
    lrcCharTime <= 1'b1;
    send(1'b1);
    check(32'(pf), 32'h0, "lrc fault"); // no lrc parity
    lrcCharTime <= 1'b0;
    crcCharTime <= 1'b1;
    oddCount <= 1'b1;
    send(1'b0);
    check(32'(pf), 32'h1, "crc fault"); // crc parity enters
    ex = shift_exp(ex, 1'b1);
    crcCharTime <= 1'b0;
    oddCount <= 1'b0;
    shiftFlag <= 1'b0;
    send(1'b1);
    rd(`TEPC_OFF_STATUS);
    check(32'(rdat[8:0]), 32'(ex), "hold"); // lrc and idle hold
    clr();
    check(32'(rdat[8:0]), 32'h0, "clear"); // clear
    $display("test syndrome done");
    shiftFlag <= 1'b1;
    wr(`TEPC_OFF_CTRL, 32'h0000_0001);
    tick(1);
    check(32'(patternShiftCtl), 32'h0, "shift ctl off"); // shift control
    for (int i = 0; i < 9; i++) begin
      k = (i == 0) ? 0 : $urandom_range(8, 1);
      cmp(9'h001, 9'h001 << k);
      check(rdat, 32'h0000_0004, "found"); // search
      check(32'(irq), 32'h0, "masked"); // masked irq
      send(1'b1);
      rd(`TEPC_OFF_CHANNEL);
      check(rdat, 32'h0000_0001 << k, "channel"); // marker
    end
    clr();
    check(32'(rdat[8:0]), 32'(9'h001 << k), "kept"); // correction kept
    cmp(9'h001, 9'h003);
    check(rdat, 32'h0000_0008, "uncorr"); // no match
    wr(`TEPC_OFF_INTMASK, 32'h0000_0010);
    cmp(`TEPC_CRC_GOOD, `TEPC_PAT_ZERO);
    check(rdat, 32'h0000_0010, "record ok"); // good record
    check(32'(irq), 32'h1, "irq on");
    wr(`TEPC_OFF_INTSTAT, 32'h0000_0010);
    tick(2);
    check(32'(irq), 32'h0, "irq off");
    $display("test compare done");
    wr(`TEPC_OFF_CTRL, 32'h0000_0000);
    readPhaseOne <= 1'b0;
    readPhaseTwo <= 1'b0;
    writePhaseOne <= 1'b1;
    clr();
    check(32'(xorLoadCtl), 32'h1, "xor ctl"); // xor control
    ex = 9'h000;
    for (int i = 0; i < 7; i++) begin
      cb = 9'($urandom);
      correctedBusBit <= cb;
      if (i == 6) wr(`TEPC_OFF_CTRL, 32'h0000_0002);
      send(1'b0);
      if (i < 6) ex ^= cb;
    end
    wr(`TEPC_OFF_CTRL, 32'h0000_0000);
    rd(`TEPC_OFF_STATUS);
    check(32'(rdat[8:0]), 32'(ex), "lrc sum"); // gated toggles
    for (int i = 0; i < 2; i++) begin
      recordEnd <= 1'b1;
      @(posedge clk);
      recordEnd <= 1'b0;
      tick(2);
      check(32'(lrcError), 32'(i == 0 && ex != 9'h000), "lrc err"); // error
      check(32'(patternAllClear), 32'(i == 1 || ex == 9'h000), "all clear");
      correctedBusBit <= ex;
      send(1'b0);
    end
    $display("test write check done");
    writePhaseOne <= 1'b0;
    readPhaseTwo <= 1'b1;
    reverseDir <= 1'b1;
    lastGapTime <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      {noFileMarker, oddCount} <= 2'(i);
      tick(3);
      check(32'(parityFault), 32'(i == 2), "last gap"); // backward check
    end
    wr(`TEPC_OFF_INTSTAT, 32'h0000_001f);
    oddCount <= 1'b0;
    tick(3);
    rd(`TEPC_OFF_INTSTAT);
    check(32'(rdat[0]), 32'h1, "fault event"); // event
    $display("test last gap done");
    finish_test();
  end
endmodule : test_tepc_check
